// [rss_alu.sv]
// Subtract and rotate datapath
`timescale 1ns/10ps
module rss_alu (
	input  wire logic [7:0] op_a,
	input  wire logic [7:0] op_b,
	input  wire logic       carry_in,
	output logic      [7:0] sub_res,
	output logic            sub_c,
	output logic            sub_dig,
	output logic            sub_z,
	output logic      [7:0] rot_res,
	output logic            rot_c
);
	logic [8:0] diff;
	logic [4:0] low;
	// ----------------------------------------------------------------
	// Two's complement subtract, carry means no borrow
	// ----------------------------------------------------------------
	assign diff    = {1'b0, op_a} + {1'b0, ~op_b} + 9'h001;
	assign low     = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + 5'h01;
	assign sub_res = diff[7:0];
	assign sub_c   = diff[8];
	assign sub_dig = low[4];
	assign sub_z   = (diff[7:0] == 8'h00);
	// ----------------------------------------------------------------
	// Rotate left through carry
	// ----------------------------------------------------------------
	assign rot_res = {op_a[6:0], carry_in};
	assign rot_c   = op_a[7];
endmodule

// [rss_cfg.svh]
// Offsets, field positions, reset values and opcodes of the decoder block
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RSS_ADDR_ACC    12'h000
`define RSS_ADDR_STATUS 12'h004
`define RSS_ADDR_WDOG   12'h008
`define RSS_ADDR_PRESC  12'h00c
`define RSS_ADDR_CTRL   12'h010
`define RSS_FILE_TAG    3'h1
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define RSS_ST_C        0
`define RSS_ST_DIG      1
`define RSS_ST_Z        2
`define RSS_ST_PDN      3
`define RSS_ST_TMO      4
`define RSS_ST_RST      5'h18
`define RSS_CTRL_WAKE   0
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define RSS_OP_ROT      6'h0d
`define RSS_OP_FSUB     6'h02
`define RSS_OP_LSUB     5'h1e
`define RSS_OP_SLEEP    14'h0063
`endif

// [rss_core.sv]
// Rotate, power-down and subtract decoder with APB register access
// Functional notes
// - Rotate file left through carry; dest bit picks acc or file.
// - Power-down instruction clears powerdown flag and sets timeout flag.
// - Power-down instruction zeroes watchdog counter and its prescaler.
// - After power-down, execution halts until a wake-up arrives.
// - Literal minus acc into acc; one opcode bit ignored; flags updated.
// - File register minus acc; seven-bit address; flags updated.
// - File subtract result goes to acc if dest 0, file if dest 1.
// - Subtract carry is 1 with no borrow, 0 on negative result.
`timescale 1ns/10ps
`include "rss_cfg.svh"
module rss_core
	import rss_pkg::*;
#(
	parameter int PC_W = 13
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic [13:0]     instr_word,
	input  wire logic            instr_valid,
	input  wire logic            wake,
	output logic      [PC_W-1:0] prog_addr,
	output logic                 fetch_en,
	output logic                 osc_halted
);
	logic [7:0]      mem [0:127];
	logic [7:0]      acc_reg;
	logic [4:0]      status_reg;
	logic [7:0]      wdog_reg;
	logic [7:0]      presc_reg;
	logic [PC_W-1:0] pc_reg;
	rss_state_t      state_reg;
	logic [31:0]     prdata_reg;
	logic            pready_reg;
	logic            pslverr_reg;
	rss_op_t         op;
	logic            exec;
	logic [6:0]      faddr;
	logic            dest;
	logic [7:0]      fsel;
	logic [7:0]      opa;
	logic [7:0]      sub_res;
	logic            sub_c;
	logic            sub_dig;
	logic            sub_z;
	logic [7:0]      rot_res;
	logic            rot_c;
	logic            wr_acc;
	logic            wr_file;
	logic [7:0]      res;
	logic            acc_w;
	logic            apb_wr;
	logic            setup;
	logic            is_file;
	logic            mapped;
	logic            wake_any;
	logic [31:0]     rd_val;
	logic            fetch_reg;
	logic            halt_reg;
	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign exec  = instr_valid && (state_reg == rss_run);
	assign faddr = instr_word[6:0];
	assign dest  = instr_word[7];
	assign fsel  = mem[faddr];
	always_comb begin
		op = rss_nop;
		if (instr_word == `RSS_OP_SLEEP)
			op = rss_pdn;
		else if (instr_word[13:8] == `RSS_OP_ROT)
			op = rss_rot;
		else if (instr_word[13:9] == `RSS_OP_LSUB)
			op = rss_lsub;
		else if (instr_word[13:8] == `RSS_OP_FSUB)
			op = rss_fsub;
	end
	assign opa = (op == rss_lsub) ? instr_word[7:0] : fsel;
	rss_alu u_alu (
		.op_a     (opa),
		.op_b     (acc_reg),
		.carry_in (status_reg[`RSS_ST_C]),
		.sub_res  (sub_res),
		.sub_c    (sub_c),
		.sub_dig  (sub_dig),
		.sub_z    (sub_z),
		.rot_res  (rot_res),
		.rot_c    (rot_c)
	);
	assign res     = (op == rss_rot) ? rot_res : sub_res;
	assign wr_acc  = exec && ((op == rss_lsub) ||
		(((op == rss_rot) || (op == rss_fsub)) && !dest));
	assign wr_file = exec && ((op == rss_rot) || (op == rss_fsub)) && dest;
	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign setup    = psel && !penable;
	assign apb_wr   = psel && penable && pready_reg && pwrite && !pslverr_reg;
	assign is_file  = (paddr[11:9] == `RSS_FILE_TAG);
	assign wake_any = wake || (apb_wr && (paddr == `RSS_ADDR_CTRL) &&
		pwdata[`RSS_CTRL_WAKE]);
	assign acc_w    = apb_wr && (paddr == `RSS_ADDR_ACC);
	always_comb begin
		rd_val = 32'h0000_0000;
		mapped = 1'b1;
		if (is_file)
			rd_val = {24'h00_0000, mem[paddr[8:2]]};
		else if (paddr == `RSS_ADDR_ACC)
			rd_val = {24'h00_0000, acc_reg};
		else if (paddr == `RSS_ADDR_STATUS)
			rd_val = {27'h000_0000, status_reg};
		else if (paddr == `RSS_ADDR_WDOG)
			rd_val = {24'h00_0000, wdog_reg};
		else if (paddr == `RSS_ADDR_PRESC)
			rd_val = {24'h00_0000, presc_reg};
		else if (paddr == `RSS_ADDR_CTRL)
			rd_val = {31'h0000_0000, state_reg == rss_sleep};
		else
			mapped = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup && !mapped;
			if (setup)
				prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
		end
	end
	// ----------------------------------------------------------------
	// Working register, execution wins over software
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acc_reg <= 8'h00;
		else if (wr_acc)
			acc_reg <= res;
		else if (acc_w)
			acc_reg <= pwdata[7:0];
	end
	// ----------------------------------------------------------------
	// File registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (wr_file)
			mem[faddr] <= res;
		else if (apb_wr && is_file)
			mem[paddr[8:2]] <= pwdata[7:0];
	end
	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_reg <= `RSS_ST_RST;
		else if (exec && (op == rss_rot))
			status_reg[`RSS_ST_C] <= rot_c;
		else if (exec && ((op == rss_lsub) || (op == rss_fsub))) begin
			status_reg[`RSS_ST_C]   <= sub_c;
			status_reg[`RSS_ST_DIG] <= sub_dig;
			status_reg[`RSS_ST_Z]   <= sub_z;
		end else if (exec && (op == rss_pdn)) begin
			status_reg[`RSS_ST_PDN] <= 1'b0;
			status_reg[`RSS_ST_TMO] <= 1'b1;
		end else if (apb_wr && (paddr == `RSS_ADDR_STATUS))
			status_reg <= pwdata[4:0];
	end
	// ----------------------------------------------------------------
	// Watchdog counter and prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_reg  <= 8'h00;
			presc_reg <= 8'h00;
		end else if (exec && (op == rss_pdn)) begin
			wdog_reg  <= 8'h00;
			presc_reg <= 8'h00;
		end else if (apb_wr && (paddr == `RSS_ADDR_WDOG))
			wdog_reg <= pwdata[7:0];
		else if (apb_wr && (paddr == `RSS_ADDR_PRESC))
			presc_reg <= pwdata[7:0];
		else if (state_reg == rss_run) begin
			presc_reg <= presc_reg + 8'h01;
			if (presc_reg == 8'hff)
				wdog_reg <= wdog_reg + 8'h01;
		end
	end
	// ----------------------------------------------------------------
	// Run and sleep sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= rss_run;
			fetch_reg <= 1'b1;
			halt_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				rss_run: begin
					if (exec && (op == rss_pdn)) begin
						state_reg <= rss_sleep;
						fetch_reg <= 1'b0;
						halt_reg  <= 1'b1;
					end
				end
				rss_sleep: begin
					if (wake_any) begin
						state_reg <= rss_run;
						fetch_reg <= 1'b1;
						halt_reg  <= 1'b0;
					end
				end
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pc_reg <= '0;
		else if (exec)
			pc_reg <= pc_reg + 1'b1;
	end
	assign prdata     = prdata_reg;
	assign pready     = pready_reg;
	assign pslverr    = pslverr_reg;
	assign prog_addr  = pc_reg;
	assign fetch_en   = fetch_reg;
	assign osc_halted = halt_reg;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rot;
		exec && (op == rss_rot) && !dest |=>
			(acc_reg == {$past(fsel[6:0]),
				$past(status_reg[`RSS_ST_C])}) &&
			(status_reg[`RSS_ST_C] == $past(fsel[7]));
	endproperty
	a_rot: assert property (p_rot) else $error("bad rotate");
	property p_pflg;
		exec && (op == rss_pdn) |=>
			!status_reg[`RSS_ST_PDN] && status_reg[`RSS_ST_TMO];
	endproperty
	a_pflg: assert property (p_pflg) else $error("bad flags");
	property p_pwdg;
		exec && (op == rss_pdn) |=>
			(wdog_reg == 8'h00) && (presc_reg == 8'h00);
	endproperty
	a_pwdg: assert property (p_pwdg) else $error("not clear");
	property p_halt;
		exec && (op == rss_pdn) ##1 !wake_any |=>
			osc_halted && $stable(pc_reg) && $stable(acc_reg);
	endproperty
	a_halt: assert property (p_halt) else $error("ran asleep");
	property p_lsub;
		exec && (op == rss_lsub) |=>
			acc_reg == ($past(instr_word[7:0]) - $past(acc_reg));
	endproperty
	a_lsub: assert property (p_lsub) else $error("lit sub");
	property p_fsw;
		exec && (op == rss_fsub) && !dest |=>
			acc_reg == ($past(fsel) - $past(acc_reg));
	endproperty
	a_fsw: assert property (p_fsw) else $error("sub to acc");
	property p_fsf;
		exec && (op == rss_fsub) && dest |=>
			(mem[$past(faddr)] == ($past(fsel) - $past(acc_reg))) &&
			$stable(acc_reg);
	endproperty
	a_fsf: assert property (p_fsf) else $error("sub to file");
	property p_carry;
		exec && ((op == rss_lsub) || (op == rss_fsub)) |=>
			status_reg[`RSS_ST_C] == ($past(opa) >= $past(acc_reg));
	endproperty
	a_carry: assert property (p_carry) else $error("carry");
	property p_zdig;
		exec && ((op == rss_lsub) || (op == rss_fsub)) |=>
			(status_reg[`RSS_ST_Z] == ($past(opa) == $past(acc_reg))) &&
			(status_reg[`RSS_ST_DIG] ==
				($past(opa[3:0]) >= $past(acc_reg[3:0])));
	endproperty
	a_zdig: assert property (p_zdig) else $error("zero flags");
endmodule

// [rss_pkg.sv]
// Types shared by the decoder block
package rss_pkg;
	typedef enum {rss_run, rss_sleep} rss_state_t;
	typedef enum {rss_nop, rss_rot, rss_pdn, rss_lsub, rss_fsub} rss_op_t;
endpackage

// [rss_prog_mem.sv]
// Program memory model feeding instruction words
`timescale 1ns/10ps
module rss_prog_mem (
	input  wire logic [12:0] prog_addr,
	input  wire logic        go,
	output logic      [13:0] instr_word,
	output logic             instr_valid
);
	logic [13:0] mem [0:8191];
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 14'h0000;
		end
	end
	// Word shown only while fetched; inverted otherwise
	assign instr_word  = go ? mem[prog_addr] : ~mem[prog_addr];
	assign instr_valid = go;
endmodule

// [tb_rotate_sleep_subtract_exec.sv]
// Self-checking bench for the decoder block
`timescale 1ns/10ps
module tb_rotate_sleep_subtract_exec;
	logic        pclk, presetn, psel, penable, pwrite, wake, go;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, fetch_en, osc_halted, e;
	logic [13:0] instr_word;
	logic        instr_valid;
	logic [12:0] prog_addr;
	int          mismatches, cmp_count;
	int          acc, c, dg, z, pdn, tmo, pc, f, k, a, d, op, res;
	int          fm [0:127];
	rss_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_word(instr_word),
		.instr_valid(instr_valid), .wake(wake), .prog_addr(prog_addr),
		.fetch_en(fetch_en), .osc_halted(osc_halted));
	rss_prog_mem pm (.prog_addr(prog_addr), .go(go),
		.instr_word(instr_word), .instr_valid(instr_valid));
	always #5 pclk = ~pclk;
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, y);
		cmp_count++;
		if (x !== y) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", n, x, y);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad,
		input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			mismatches++;
			report_and_stop();
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rchk(input string n, input logic [11:0] ad, input int x);
		apb(0, ad, 0);
		chk(n, x, r);
	endtask
	task automatic exec(input logic [13:0] ins, input bit run);
		pm.mem[pc] = ins;
		@(posedge pclk);
		go <= 1;
		@(posedge pclk);
		go <= 0;
		if (run)
			pc++;
	endtask
	task automatic sub(input int x, y);
		res = (x - y) & 255;
		c = x >= y;
		dg = (x & 15) >= (y & 15);
		z = res == 0;
	endtask
	task automatic state_chk();
		rchk("acc", 12'h000, acc);
		rchk("status", 12'h004, tmo*16 + pdn*8 + z*4 + dg*2 + c);
		rchk("file", 12'h200 + 4*f, fm[f]);
		chk("pc", pc, 32'(prog_addr));
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, wake, go} = '0;
		paddr = '0;
		pwdata = '0;
		acc = 0;
		c = 0;
		dg = 0;
		z = 0;
		pc = 0;
		f = 0;
		pdn = 1;
		tmo = 1;
		void'($urandom(79));
		repeat (8) @(posedge pclk);
		presetn <= 1;
		rchk("status", 12'h004, 32'h18);
		for (int n = 0; n < 30; n++) begin
			op = n % 3;
			f = (n < 3) ? 127 : $urandom % 128;
			d = $urandom % 2;
			acc = $urandom % 256;
			a = (n % 4 == 0) ? acc : $urandom % 256;
			k = (n % 5 == 0) ? acc : $urandom % 256;
			apb(1, 12'h000, acc);
			apb(1, 12'h200 + 4*f, a);
			fm[f] = a;
			if (op == 0) begin
				exec({6'h0d, d[0], f[6:0]}, 1);
				res = ((a << 1) | c) & 255;
				c = a >> 7;
				if (d) fm[f] = res; else acc = res;
			end else if (op == 1) begin
				exec({5'h1e, d[0], k[7:0]}, 1);
				sub(k, acc);
				acc = res;
			end else begin
				exec({6'h02, d[0], f[6:0]}, 1);
				sub(a, acc);
				if (d) fm[f] = res; else acc = res;
			end
			state_chk();
		end
		exec(14'h0063, 1);
		pdn = 0;
		tmo = 1;
		state_chk();
		rchk("wdt", 12'h008, 0);
		rchk("presc", 12'h00c, 0);
		chk("halted", 1, osc_halted);
		chk("fetch", 0, fetch_en);
		exec(14'h3c77, 0);
		state_chk();
		@(posedge pclk);
		wake <= 1;
		@(posedge pclk);
		wake <= 0;
		repeat (2) @(posedge pclk);
		chk("halted", 0, osc_halted);
		exec(14'h3d77, 1);
		sub(8'h77, acc);
		acc = res;
		state_chk();
		exec(14'h0063, 1);
		rchk("ctrl", 12'h010, 1);
		apb(1, 12'h010, 1);
		@(posedge pclk);
		chk("halted", 0, osc_halted);
		chk("fetch", 1, fetch_en);
		apb(0, 12'h0fc, 0);
		chk("pslverr", 1, e);
		chk("prdata", 0, r);
		report_and_stop();
	end
endmodule
